// file: hw/gpt_pkg.sv
// Constants, types and register map of the general-purpose timer module.
// Assumes a 32-bit APB register bus and one clock for the whole module.
package gpt_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] GPT_OFF_CFG_A = 8'h00;
  localparam logic [7:0] GPT_OFF_CFG_B = 8'h04;
  localparam logic [7:0] GPT_OFF_CTL = 8'h08;
  localparam logic [7:0] GPT_OFF_LD_A = 8'h0C;
  localparam logic [7:0] GPT_OFF_LD_B = 8'h10;
  localparam logic [7:0] GPT_OFF_MT_A = 8'h14;
  localparam logic [7:0] GPT_OFF_MT_B = 8'h18;
  localparam logic [7:0] GPT_OFF_PS_A = 8'h1C;
  localparam logic [7:0] GPT_OFF_PS_B = 8'h20;
  localparam logic [7:0] GPT_OFF_PM_A = 8'h24;
  localparam logic [7:0] GPT_OFF_PM_B = 8'h28;
  localparam logic [7:0] GPT_OFF_LD_BOTH = 8'h2C;
  localparam logic [7:0] GPT_OFF_MT_BOTH = 8'h30;
  localparam logic [7:0] GPT_OFF_PS_BOTH = 8'h34;
  localparam logic [7:0] GPT_OFF_PM_BOTH = 8'h38;
  localparam logic [7:0] GPT_OFF_HI = 8'h3C;
  localparam logic [7:0] GPT_OFF_SYNC = 8'h40;
  localparam logic [7:0] GPT_OFF_CNT_A = 8'h44;
  localparam logic [7:0] GPT_OFF_CNT_B = 8'h48;

  // ==========================================================
  // Fields and reset values
  localparam int GPT_NUM_SYNC = 24;
  localparam int gpt_std_module_half_sync_select = 0;
  localparam int gpt_wide_module_half_sync_select = 12;
  localparam int GPT_CTL_FULL_BIT = 0;
  localparam int GPT_CTL_RTC_EN_BIT = 1;
  localparam logic [7:0] GPT_HALF_CFG_RST = 8'hC0;
  localparam logic [31:0] GPT_RD_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    GPT_ONE_SHOT,
    GPT_PERIODIC,
    GPT_RTC,
    GPT_CAP_COUNT,
    GPT_PWM
  } gpt_mode_t;

  // Per-half configuration word, bit 0 at the bottom of mode
  typedef struct packed {
    logic immediate_match_update;
    logic immediate_load_update;
    logic match_int_en;
    logic count_up;
    logic enable;
    gpt_mode_t mode;
  } gpt_half_cfg_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } gpt_apb_req_t;

endpackage : gpt_pkg

// file: hw/gpt_timer_module.sv
// One timer module: two halves, split or joined, with APB registers.
// Assumes a synchronous capture input per half and the sync lines of the
// first module wired to sync_in of every other module.
//
// Summary of operation
// - A load write reloads a down-counting counter at once under immediate update.
// - Joined halves use only first-half load and match; second-half writes drop.
// - Narrow modules use one 32-bit word; wide joined uses a 64-bit path.
// - A wide joined module takes one 64-bit load, reloading a down-counting counter under immediate update.
// - Capture count mode flags a match when edge count equals match.
// - PWM output drops when the count reaches the match value.
// - Periodic and one-shot modes may flag matches when enabled.
// - Match and prescale values read back as last written per half.
// - Prescaler works only in split mode; joined mode ignores it.
// - Down-counting periodic or one-shot: prescaler forms the low bits.
// - All other modes: prescaler forms the high bits.
// - Prescale match joins the match value in counter bit order.
// - Prescale fields are 8 bits narrow, 16 bits wide; software stays within.
// - Clearing the clock-mode enable halts the counter holding its value.
// - The clock-mode enable starts counting only in clock mode.
// - One sync control in the first module restarts selected halves together.
// - Sync control holds 24 selects: two halves of six plus six modules.
// - In split mode each half follows its own sync select.
// - In joined mode only the first-half select syncs; the other is ignored.
// - Deferred load applies a new load only when counting down reaches zero.
// - Deferred match applies only at zero when down counting; not when up.
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module gpt_timer_module
  import gpt_pkg::*;
#(
  parameter int HW = 16,
  parameter int PW = 8,
  parameter bit FIRST = 1'b1,
  parameter int SYNC_BASE = gpt_std_module_half_sync_select
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Register bus
  input wire gpt_apb_req_t apb_req_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Capture and synchronisation
  input wire logic [1:0] cap_in,
  input wire logic [1:0] sync_in,
  output logic [GPT_NUM_SYNC-1:0] sync_out,
  // Timer events
  output logic [1:0] timeout_out,
  output logic [1:0] match_out,
  output logic [1:0] pwm_out
);

  localparam int CW = 2 * HW;
  localparam int EW = HW + PW;

  // ==========================================================
  // State
  gpt_half_cfg_t cfg_r [2];
  logic full_r, rtc_en_r;
  logic [HW-1:0] load_r [2], match_r [2], mact_r [2], cnt_r [2], hi_r;
  logic [PW-1:0] pre_r [2], pmatch_r [2], pmact_r [2], pcnt_r [2];
  logic [1:0] ld_pend_r, mt_pend_r, cap_d_r;

  gpt_half_cfg_t hc [2];
  logic [CW-1:0] cur [2], lv [2], cm [2], nv [2];
  logic [CW+1:0] res [2];
  logic [1:0] lsb, dn, run, tick, syn, tmo, hit, evt, ap, wld, wmt, wps, wpm, sync_src;
  logic acc, wr, mapped;
  logic [7:0] a;
  logic [31:0] wd, rd;
  logic [CW-1:0] wide;

  function automatic logic hit2(input logic [7:0] ad, input logic [7:0] oa,
                                input logic [7:0] ob, input logic [7:0] obth,
                                input int i, input logic fl);
    hit2 = ((ad == oa && i == 0) || (ad == ob && i == 1) || ad == obth) && !(fl && i == 1);
  endfunction : hit2

  // One counting step: {timeout, match hit, next value}
  function automatic logic [CW+1:0] step(input logic [CW-1:0] c, input logic [CW-1:0] l,
                                         input logic [CW-1:0] m, input logic d,
                                         input logic os);
    logic [CW-1:0] n;
    logic t;
    n = c;
    t = 1'b0;
    if (d) begin
      if (c == '0) begin
        t = 1'b1;
        n = os ? c : l;
      end else begin
        n = c - 1'b1;
      end
    end else if (c == l) begin
      t = 1'b1;
      n = os ? c : '0;
    end else begin
      n = c + 1'b1;
    end
    // A match is the count arriving at the value, so a held count does not repeat it
    step = {t, (n == m) && (n != c), n};
  endfunction : step

  // ==========================================================
  // Bus decode
  assign acc = apb_req_in.psel && apb_req_in.penable && pready_out;
  assign wr = acc && apb_req_in.pwrite;
  assign a = apb_req_in.paddr;
  assign wd = apb_req_in.pwdata;
  // Narrow: the 32-bit word is the joined value; wide: high word staged first
  assign wide = CW'({hi_r, wd});

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      wld[i] = wr && hit2(a, GPT_OFF_LD_A, GPT_OFF_LD_B, GPT_OFF_LD_BOTH, i, full_r);
      wmt[i] = wr && hit2(a, GPT_OFF_MT_A, GPT_OFF_MT_B, GPT_OFF_MT_BOTH, i, full_r);
      wps[i] = wr && hit2(a, GPT_OFF_PS_A, GPT_OFF_PS_B, GPT_OFF_PS_BOTH, i, 1'b0);
      wpm[i] = wr && hit2(a, GPT_OFF_PM_A, GPT_OFF_PM_B, GPT_OFF_PM_BOTH, i, 1'b0);
    end
  end

  // ==========================================================
  // Counting lanes
  assign sync_src = FIRST ? sync_out[SYNC_BASE +: 2] : sync_in;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      hc[i] = cfg_r[full_r ? 0 : i];
      lsb[i] = (hc[i].mode == GPT_ONE_SHOT || hc[i].mode == GPT_PERIODIC)
               && !hc[i].count_up;
      dn[i] = lsb[i] || hc[i].mode == GPT_PWM;
      run[i] = hc[i].enable && (hc[i].mode != GPT_RTC || rtc_en_r);
      tick[i] = run[i] && (hc[i].mode != GPT_CAP_COUNT || (cap_in[i] && !cap_d_r[i]));
      syn[i] = sync_src[i] && !(full_r && i == 1);
      // Prescaler above the count in all other modes
      cur[i] = lsb[i] ? CW'({cnt_r[i], pcnt_r[i]}) : CW'({pcnt_r[i], cnt_r[i]});
      lv[i] = lsb[i] ? CW'({load_r[i], pre_r[i]}) : CW'({pre_r[i], load_r[i]});
      cm[i] = lsb[i] ? CW'({mact_r[i], pmact_r[i]}) : CW'({pmact_r[i], mact_r[i]});
    end
    if (full_r) begin
      cur[0] = {cnt_r[1], cnt_r[0]};
      lv[0] = {load_r[1], load_r[0]};
      cm[0] = {mact_r[1], mact_r[0]};
    end
    for (int i = 0; i < 2; i++) begin
      res[i] = step(cur[i], lv[i], cm[i], dn[i], hc[i].mode == GPT_ONE_SHOT);
      nv[i] = cur[i];
      tmo[i] = 1'b0;
      hit[i] = 1'b0;
      if (syn[i]) begin
        nv[i] = dn[i] ? lv[i] : '0;
      end else if (ld_pend_r[i] && dn[i]) begin
        nv[i] = lv[i];
      end else if (tick[i]) begin
        nv[i] = res[i][CW-1:0];
        tmo[i] = res[i][CW+1];
        hit[i] = res[i][CW];
      end
      // Match events: capture count and clock mode always, one-shot and periodic on request, PWM never
      evt[i] = hit[i] && (hc[i].mode == GPT_CAP_COUNT || hc[i].mode == GPT_RTC
               || (hc[i].match_int_en && (hc[i].mode == GPT_ONE_SHOT
               || hc[i].mode == GPT_PERIODIC)));
      // Deferred match waits for zero only while counting down
      ap[i] = mt_pend_r[i] && (hc[i].immediate_match_update || !dn[i] || tmo[i]);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      cnt_r <= '{default: '0};
      pcnt_r <= '{default: '0};
    end else if (full_r) begin
      cnt_r[0] <= nv[0][HW-1:0];
      cnt_r[1] <= nv[0][CW-1:HW];
    end else begin
      for (int i = 0; i < 2; i++) begin
        cnt_r[i] <= lsb[i] ? nv[i][EW-1:PW] : nv[i][HW-1:0];
        pcnt_r[i] <= lsb[i] ? nv[i][PW-1:0] : nv[i][EW-1:HW];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      timeout_out <= 2'h0;
      match_out <= 2'h0;
      pwm_out <= 2'h0;
      cap_d_r <= 2'h0;
    end else begin
      cap_d_r <= cap_in;
      for (int i = 0; i < 2; i++) begin
        timeout_out[i] <= tmo[i] && !(full_r && i == 1);
        match_out[i] <= evt[i] && !(full_r && i == 1);
        if (hc[i].mode != GPT_PWM || (full_r && i == 1)) begin
          pwm_out[i] <= 1'b0;
        end else if (hit[i]) begin
          pwm_out[i] <= 1'b0;
        end else if (tmo[i] || syn[i]) begin
          pwm_out[i] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Programmed values
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      load_r <= '{default: '0};
      match_r <= '{default: '0};
      hi_r <= '0;
    end else begin
      if (wr && a == GPT_OFF_HI) begin
        hi_r <= wd[HW-1:0];
      end
      for (int i = 0; i < 2; i++) begin
        if (wld[i]) begin
          load_r[i] <= wd[HW-1:0];
        end
        if (wmt[i]) begin
          match_r[i] <= wd[HW-1:0];
        end
      end
      if (full_r && wld[0]) begin
        {load_r[1], load_r[0]} <= wide;
      end
      if (full_r && wmt[0]) begin
        {match_r[1], match_r[0]} <= wide;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pre_r <= '{default: '0};
      pmatch_r <= '{default: '0};
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wps[i]) begin
          pre_r[i] <= wd[PW-1:0];
        end
        if (wpm[i]) begin
          pmatch_r[i] <= wd[PW-1:0];
        end
      end
    end
  end

  // A write that meets the apply edge keeps its pending flag, so it is not lost
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ld_pend_r <= 2'h0;
      mt_pend_r <= 2'h0;
      mact_r <= '{default: '0};
      pmact_r <= '{default: '0};
    end else begin
      for (int i = 0; i < 2; i++) begin
        ld_pend_r[i] <= wld[i] && hc[i].immediate_load_update;
        mt_pend_r[i] <= wmt[i] || wpm[i] || (mt_pend_r[i] && !ap[i]);
        if (ap[i] && !full_r) begin
          mact_r[i] <= match_r[i];
          pmact_r[i] <= pmatch_r[i];
        end
      end
      if (ap[0] && full_r) begin
        mact_r[0] <= match_r[0];
        mact_r[1] <= match_r[1];
      end
    end
  end

  // ==========================================================
  // Control registers and sync
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      cfg_r <= '{default: gpt_half_cfg_t'(GPT_HALF_CFG_RST)};
      full_r <= 1'b0;
      rtc_en_r <= 1'b0;
    end else begin
      if (wr && a == GPT_OFF_CFG_A) begin
        cfg_r[0] <= gpt_half_cfg_t'(wd[7:0]);
      end
      if (wr && a == GPT_OFF_CFG_B) begin
        cfg_r[1] <= gpt_half_cfg_t'(wd[7:0]);
      end
      if (wr && a == GPT_OFF_CTL) begin
        full_r <= wd[GPT_CTL_FULL_BIT];
        rtc_en_r <= wd[GPT_CTL_RTC_EN_BIT];
      end
    end
  end

  // One-cycle select pulses; only the first module owns the control
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sync_out <= '0;
    end else begin
      sync_out <= (FIRST && wr && a == GPT_OFF_SYNC) ? wd[GPT_NUM_SYNC-1:0] : '0;
    end
  end

  // ==========================================================
  // APB slave: one wait state, error on unmapped addresses
  always_comb begin
    rd = GPT_RD_ZERO;
    mapped = 1'b1;
    unique case (a)
      GPT_OFF_CFG_A: rd = 32'(cfg_r[0]);
      GPT_OFF_CFG_B: rd = 32'(cfg_r[1]);
      GPT_OFF_CTL: rd = 32'({rtc_en_r, full_r});
      GPT_OFF_LD_A: rd = full_r ? 32'({load_r[1], load_r[0]}) : 32'(load_r[0]);
      GPT_OFF_LD_B: rd = 32'(load_r[1]);
      GPT_OFF_MT_A: rd = full_r ? 32'({match_r[1], match_r[0]}) : 32'(match_r[0]);
      GPT_OFF_MT_B: rd = 32'(match_r[1]);
      GPT_OFF_PS_A: rd = 32'(pre_r[0]);
      GPT_OFF_PS_B: rd = 32'(pre_r[1]);
      GPT_OFF_PM_A: rd = 32'(pmatch_r[0]);
      GPT_OFF_PM_B: rd = 32'(pmatch_r[1]);
      GPT_OFF_HI: rd = 32'(hi_r);
      GPT_OFF_CNT_A: rd = full_r ? 32'({cnt_r[1], cnt_r[0]}) : 32'(cnt_r[0]);
      GPT_OFF_CNT_B: rd = 32'(cnt_r[1]);
      GPT_OFF_LD_BOTH, GPT_OFF_MT_BOTH, GPT_OFF_PS_BOTH, GPT_OFF_PM_BOTH,
      GPT_OFF_SYNC: rd = GPT_RD_ZERO;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= '0;
    end else begin
      pready_out <= apb_req_in.psel && apb_req_in.penable && !pready_out;
      pslverr_out <= apb_req_in.psel && apb_req_in.penable && !pready_out && !mapped;
      prdata_out <= rd;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_imm_load;
    ld_pend_r[0] && lsb[0] && !syn[0] && !full_r
      |=> cnt_r[0] == $past(load_r[0]) && pcnt_r[0] == $past(pre_r[0]);
  endproperty
  a_imm_load: assert property (p_imm_load) else $error("load not taken at once");

  property p_full_b;
    full_r && wr && a == GPT_OFF_LD_B |=> $stable(load_r[1]);
  endproperty
  a_full_b: assert property (p_full_b) else $error("second half load written");

  property p_wide_ld;
    full_r && wr && a == GPT_OFF_LD_A
      |=> {load_r[1], load_r[0]} == CW'({$past(hi_r), $past(wd)});
  endproperty
  a_wide_ld: assert property (p_wide_ld) else $error("joined load wrong");

  property p_cap_irq;
    !full_r && hc[0].mode == GPT_CAP_COUNT && tick[0] && !syn[0] && !ld_pend_r[0]
      && nv[0] == cm[0] && nv[0] != cur[0] |=> match_out[0];
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("capture match missed");

  property p_pwm;
    !full_r && hc[1].mode == GPT_PWM && hit[1] |=> !pwm_out[1];
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm did not drop");

  property p_mint;
    hc[0].mode == GPT_PERIODIC && !hc[0].match_int_en |=> !match_out[0];
  endproperty
  a_mint: assert property (p_mint) else $error("unrequested match event");

  property p_full_pre;
    full_r |=> $stable(pcnt_r[0]) && $stable(pcnt_r[1]);
  endproperty
  a_full_pre: assert property (p_full_pre) else $error("prescaler moved joined");

  property p_rtc_hold;
    (!full_r && hc[0].mode == GPT_RTC && !rtc_en_r && !syn[0] && !ld_pend_r[0])
      [*2] |-> $stable(cnt_r[0]) && $stable(pcnt_r[0]);
  endproperty
  a_rtc_hold: assert property (p_rtc_hold) else $error("clock mode not halted");

  property p_sync_up;
    !full_r && syn[0] && !dn[0] |=> cnt_r[0] == '0 && pcnt_r[0] == '0;
  endproperty
  a_sync_up: assert property (p_sync_up) else $error("sync did not clear");

  property p_both;
    !full_r && wr && a == GPT_OFF_LD_BOTH |=> load_r[0] == load_r[1];
  endproperty
  a_both: assert property (p_both) else $error("both-half load differs");

endmodule : gpt_timer_module

`default_nettype wire

// file: tb/gp_timer_load_match_prescale_bench.sv
// Self-checking bench for one narrow first timer module driven over APB.
// Assumes the package register map and the one-wait-state slave of the design.
`timescale 1ns/1ps
`default_nettype none

module gp_timer_load_match_prescale_bench;
  import gpt_pkg::*;

  typedef struct packed {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [7:0] ra;
    logic [31:0] re;
    logic bad;
  } gpt_row_t;

  // ==========================================================
  // Register rows: write one place, read the same or another back
  localparam gpt_row_t ROWS [11] = '{
    '{GPT_OFF_MT_A, 32'h1234, GPT_OFF_MT_A, 32'h1234, 1'b0},
    '{GPT_OFF_MT_B, 32'h00AB, GPT_OFF_MT_B, 32'h00AB, 1'b0},
    '{GPT_OFF_PS_A, 32'h00FF, GPT_OFF_PS_A, 32'h00FF, 1'b0},
    '{GPT_OFF_PM_B, 32'h00F0, GPT_OFF_PM_B, 32'h00F0, 1'b0},
    '{GPT_OFF_LD_A, 32'h0007, GPT_OFF_LD_A, 32'h0007, 1'b0},
    '{GPT_OFF_MT_BOTH, 32'h0042, GPT_OFF_MT_A, 32'h0042, 1'b0},
    '{GPT_OFF_MT_BOTH, 32'h0042, GPT_OFF_MT_B, 32'h0042, 1'b0},
    '{GPT_OFF_PS_BOTH, 32'h0033, GPT_OFF_PS_B, 32'h0033, 1'b0},
    '{GPT_OFF_LD_BOTH, 32'h0009, GPT_OFF_LD_B, 32'h0009, 1'b0},
    '{GPT_OFF_PM_BOTH, 32'h0011, GPT_OFF_PM_A, 32'h0011, 1'b0},
    '{8'h4C, 32'h0005, 8'h4C, 32'h0000, 1'b1}
  };

  // ==========================================================
  // Clock, design and event counters
  logic ref_clk_in;
  logic rst_n_in;
  gpt_apb_req_t req;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] cap;
  logic [1:0] tmo;
  logic [1:0] mat;
  logic [1:0] pwm;
  logic [23:0] syn;
  logic [23:0] syn_seen;
  int err_total;
  int checks;
  int cyc;
  int mcnt;

  gpt_timer_module #(.HW(16), .PW(8), .FIRST(1'b1), .SYNC_BASE(0)) dut (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .apb_req_in(req),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .cap_in(cap), .sync_in(2'h0), .sync_out(syn),
    .timeout_out(tmo), .match_out(mat), .pwm_out(pwm));

  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  // Pulses last one cycle, so they are counted at every edge
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (mat[0] === 1'b1) mcnt <= mcnt + 1;
    if (syn !== 24'h0) syn_seen <= syn;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  // ==========================================================
  // Checks and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_in(input int n, input int lo, input int hi);
    checks++;
    if (n < lo || n > hi) begin
      err_total++;
      $display("unexpected at %0t: count %0d not in %0d..%0d", $time, n, lo, hi);
    end
  endtask : chk_in

  task automatic wrap_up();
    if (err_total == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================
  // APB master: request held until pready is seen at a rising edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] rdat, output logic err);
    @(posedge ref_clk_in);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge ref_clk_in);
    req.penable <= 1'b1;
    // Only pready or the bench timeout ends this wait
    do begin
      @(posedge ref_clk_in);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    req <= '0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
  endtask : rd

  // Cycles until the next timeout pulse of half A
  task automatic wait_to(input int lim, output int n);
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (tmo[0] !== 1'b1 && n < lim);
  endtask : wait_to

  task automatic pulse_cap(input int k);
    repeat (k) begin
      @(posedge ref_clk_in);
      cap[0] <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      cap[0] <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
    end
  endtask : pulse_cap

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [31:0] r2;
    logic e;
    int n;
    int h;
    int m0;
    rst_n_in = 1'b0;
    req = '0;
    cap = 2'h0;
    err_total = 0;
    checks = 0;
    cyc = 0;
    mcnt = 0;
    syn_seen = 24'h0;
    repeat (16) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk({pready, pslverr, tmo, mat, pwm}, 32'h0);
    @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rd(GPT_OFF_CFG_A, r);
    chk(r, {24'h0, GPT_HALF_CFG_RST});
    foreach (ROWS[k]) begin
      apb(ROWS[k].wa, 1'b1, ROWS[k].wd, r, e);
      chk(e, ROWS[k].bad);
      apb(ROWS[k].ra, 1'b0, 32'h0, r, e);
      chk(r, ROWS[k].re);
      chk(e, ROWS[k].bad);
    end
    // Periodic down count; the prescaler is the low byte of the count
    wr(GPT_OFF_PS_A, 32'h3);
    wr(GPT_OFF_PM_A, 32'h0);
    wr(GPT_OFF_LD_A, 32'h0);
    wr(GPT_OFF_CFG_A, 32'hC9);
    wait_to(100, n);
    wait_to(100, n);
    chk_in(n, 4, 4);
    // Load 1 with prescale 3 is 0x103: a period of 260 cycles
    wr(GPT_OFF_LD_A, 32'h1);
    repeat (3) wait_to(400, n);
    chk_in(n, 260, 260);
    wr(GPT_OFF_LD_A, 32'h0);
    wait_to(100, n);
    chk_in(n, 1, 6);
    // Deferred load: a short load written early in a long period waits
    wr(GPT_OFF_LD_A, 32'h1);
    wr(GPT_OFF_CFG_A, 32'h89);
    repeat (2) wait_to(400, n);
    wr(GPT_OFF_LD_A, 32'h0);
    wait_to(400, n);
    chk_in(n, 250, 260);
    wait_to(100, n);
    chk_in(n, 4, 4);
    // PWM on half B: exact window of ten periods hides the phase
    wr(GPT_OFF_PS_B, 32'h0);
    wr(GPT_OFF_PM_B, 32'h0);
    wr(GPT_OFF_LD_B, 32'h9);
    wr(GPT_OFF_MT_B, 32'h3);
    wr(GPT_OFF_CFG_B, 32'hCC);
    repeat (30) @(negedge ref_clk_in);
    h = 0;
    repeat (100) begin
      @(negedge ref_clk_in);
      if (pwm[1] === 1'b1) h++;
    end
    chk_in(h, 60, 70);
    wr(GPT_OFF_CFG_B, 32'hC0);
    // Capture count, with a prescale match that lifts the compare out of reach
    wr(GPT_OFF_CFG_A, 32'hC0);
    wr(GPT_OFF_LD_A, 32'hFF);
    wr(GPT_OFF_MT_A, 32'h3);
    wr(GPT_OFF_PM_A, 32'h1);
    wr(GPT_OFF_CFG_A, 32'hDB);
    // Sync clears the up count, so the edge count starts from zero
    wr(GPT_OFF_SYNC, 32'h1);
    m0 = mcnt;
    pulse_cap(3);
    repeat (4) @(posedge ref_clk_in);
    chk_in(mcnt - m0, 0, 0);
    wr(GPT_OFF_PM_A, 32'h0);
    wr(GPT_OFF_MT_A, 32'h5);
    pulse_cap(2);
    repeat (4) @(posedge ref_clk_in);
    chk_in(mcnt - m0, 1, 1);
    // Clock-mode enable: count held outside clock mode, runs in clock mode, halts when cleared
    wr(GPT_OFF_CTL, 32'h2);
    rd(GPT_OFF_CNT_A, r);
    rd(GPT_OFF_CNT_A, r2);
    chk(r === r2, 32'h1);
    wr(GPT_OFF_CFG_A, 32'hCA);
    rd(GPT_OFF_CNT_A, r);
    rd(GPT_OFF_CNT_A, r2);
    chk(r !== r2, 32'h1);
    wr(GPT_OFF_CTL, 32'h0);
    rd(GPT_OFF_CNT_A, r);
    rd(GPT_OFF_CNT_A, r2);
    chk(r === r2, 32'h1);
    // Joined halves: second-half writes are dropped
    wr(GPT_OFF_CFG_A, 32'hC0);
    wr(GPT_OFF_CTL, 32'h1);
    wr(GPT_OFF_MT_A, 32'h0005_0006);
    wr(GPT_OFF_MT_B, 32'h0000_0077);
    rd(GPT_OFF_MT_A, r);
    chk(r, 32'h0005_0006);
    rd(GPT_OFF_MT_B, r);
    chk(r, 32'h0000_0005);
    wr(GPT_OFF_LD_A, 32'h0003_0004);
    wr(GPT_OFF_LD_B, 32'h0000_0099);
    rd(GPT_OFF_LD_A, r);
    chk(r, 32'h0003_0004);
    // Sync restarts half A mid-period; both ends of the select field used
    wr(GPT_OFF_CTL, 32'h0);
    wr(GPT_OFF_PS_A, 32'h32);
    wr(GPT_OFF_LD_A, 32'h0);
    wr(GPT_OFF_CFG_A, 32'hC9);
    repeat (2) wait_to(200, n);
    wr(GPT_OFF_SYNC, 32'h0080_0001);
    wait_to(200, n);
    chk_in(n, 52, 56);
    chk(syn_seen, 32'h0080_0001);
    wrap_up();
  end

endmodule : gp_timer_load_match_prescale_bench

`default_nettype wire
